// *** logic/sfsc_top.sv ***
// slot fifo format, slot enable and sample trigger configuration
`timescale 1ns/1ps
module sfsc_top
  import sfsc_pkg::*;
#(
  parameter int unsigned PERIOD_CYC = SAMPLE_PERIOD_CYC
)(
  input  wire logic                       CLK,
  input  wire logic                       RST,
  input  wire logic                       REG_WR,
  input  wire logic                       REG_RD,
  input  wire logic [sfsc_pkg::ADDR_W-1:0] REG_ADDR,
  input  wire logic [sfsc_pkg::DATA_W-1:0] REG_WDATA,
  output logic      [sfsc_pkg::DATA_W-1:0] REG_RDATA,
  input  wire logic                       EXT_SYNC,
  input  wire logic                       DIG_INT_MODE,
  input  wire logic [sfsc_pkg::CH_W-1:0]   CH0_DATA,
  input  wire logic [sfsc_pkg::CH_W-1:0]   CH1_DATA,
  input  wire logic [sfsc_pkg::CH_W-1:0]   CH2_DATA,
  input  wire logic [sfsc_pkg::CH_W-1:0]   CH3_DATA,
  input  wire logic [sfsc_pkg::CH_W-1:0]   SAMPLE_DATA,
  input  wire logic [sfsc_pkg::CH_W-1:0]   BKG_DATA,
  output logic                            FIFO_WR,
  output logic      [sfsc_pkg::DATA_W-1:0] FIFO_DATA
);
  import sfsc_pkg::*;

  logic [DATA_W-1:0] opmode_reg,    opmode_next;
  logic [DATA_W-1:0] slot_fifo_reg, slot_fifo_next;
  logic [DATA_W-1:0] sync_trig_reg, sync_trig_next;
  logic [DATA_W-1:0] smp_clk_reg,   smp_clk_next;
  logic [DATA_W-1:0] rdata_reg,     rdata_next;

  logic [1:0]        op_mode;
  logic [2:0]        fifo_fmt;
  logic              slot_en;
  logic              ext_en;
  logic              running;
  logic              trig;
  logic              start;

  logic [CH_W-1:0]   ch [NUM_CH];
  logic [15:0]       sum16;
  logic [31:0]       sum32;
  logic [DATA_W-1:0] words [MAX_WORDS];
  logic [3:0]        n_words;

  sfsc_state_e       state_reg,     state_next;
  logic [DATA_W-1:0] wbuf_reg [MAX_WORDS];
  logic [DATA_W-1:0] wbuf_next [MAX_WORDS];
  logic [3:0]        n_reg,         n_next;
  logic [3:0]        idx_reg,       idx_next;
  logic              fifo_wr_reg,   fifo_wr_next;
  logic [DATA_W-1:0] fifo_data_reg, fifo_data_next;

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------

  // writes store whole words, reads return the addressed register
  always_comb
  begin
    opmode_next    = opmode_reg;
    slot_fifo_next = slot_fifo_reg;
    sync_trig_next = sync_trig_reg;
    smp_clk_next   = smp_clk_reg;
    rdata_next     = rdata_reg;
    if (REG_WR)
    begin
      case (REG_ADDR)
        OFF_OPMODE:    opmode_next    = REG_WDATA;
        OFF_SLOT_FIFO: slot_fifo_next = REG_WDATA;
        OFF_SYNC_TRIG: sync_trig_next = REG_WDATA;
        OFF_SMP_CLK:   smp_clk_next   = REG_WDATA;
        default:       ;
      endcase
    end
    if (REG_RD)
    begin
      case (REG_ADDR)
        OFF_OPMODE:    rdata_next = opmode_reg;
        OFF_SLOT_FIFO: rdata_next = slot_fifo_reg;
        OFF_SYNC_TRIG: rdata_next = sync_trig_reg;
        OFF_SMP_CLK:   rdata_next = smp_clk_reg;
        default:       rdata_next = '0; // unmapped reads as zero
      endcase
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      opmode_reg    <= RST_OPMODE;
      slot_fifo_reg <= RST_SLOT_FIFO;
      sync_trig_reg <= RST_SYNC_TRIG;
      smp_clk_reg   <= RST_SMP_CLK;
      rdata_reg     <= '0;
    end
    else
    begin
      opmode_reg    <= opmode_next;
      slot_fifo_reg <= slot_fifo_next;
      sync_trig_reg <= sync_trig_next;
      smp_clk_reg   <= smp_clk_next;
      rdata_reg     <= rdata_next;
    end
  end

  // field extraction
  assign op_mode  = opmode_reg[OPMODE_LSB +: 2];
  assign fifo_fmt = slot_fifo_reg[FIFO_FMT_LSB +: 3];
  assign slot_en  = slot_fifo_reg[SLOT_EN_BIT];
  assign ext_en   = sync_trig_reg[EXT_TRIG_BIT];
  assign running  = (op_mode == MODE_NORMAL);

  // ----------------------------------------------------------------
  // trigger and start
  // ----------------------------------------------------------------
  sfsc_trig #(
    .PERIOD_CYC (PERIOD_CYC)
  ) u_trig (
    .clk      (CLK),
    .rst      (RST),
    .run      (running),
    .ext_en   (ext_en),
    .ext_sync (EXT_SYNC),
    .trig     (trig)
  );

  // a period starts only in normal mode, slot enabled, with words to push
  assign start = trig && running && slot_en && (n_words != 4'h0)
                 && (state_reg == SFSC_IDLE);

  // ----------------------------------------------------------------
  // word formatting
  // ----------------------------------------------------------------
  assign ch[0] = CH0_DATA;
  assign ch[1] = CH1_DATA;
  assign ch[2] = CH2_DATA;
  assign ch[3] = CH3_DATA;

  // build the word list for one period, high half of a 32-bit value first
  always_comb
  begin
    sum16   = '0;
    sum32   = '0;
    n_words = 4'h0;
    for (int i = 0; i < NUM_CH; i++)
    begin
      sum16 = sum16 + ch[i][15:0];
      sum32 = sum32 + ch[i];
    end
    for (int i = 0; i < MAX_WORDS; i++)
    begin
      words[i] = '0;
    end
    case (fifo_fmt)
      FMT_W16:
      begin
        n_words  = 4'h1;
        words[0] = DIG_INT_MODE ? SAMPLE_DATA[15:0] : sum16;
      end
      FMT_W32:
      begin
        n_words  = 4'h2;
        words[0] = DIG_INT_MODE ? SAMPLE_DATA[31:16] : sum32[31:16];
        words[1] = DIG_INT_MODE ? SAMPLE_DATA[15:0] : sum32[15:0];
      end
      FMT_W16BG:
      begin
        if (DIG_INT_MODE)
        begin
          n_words  = 4'h2;
          words[0] = SAMPLE_DATA[15:0];
          words[1] = BKG_DATA[15:0];
        end
      end
      FMT_W32BG:
      begin
        n_words = 4'h4;
        for (int i = 0; i < NUM_CH; i++)
        begin
          words[i] = ch[i][15:0];
        end
        if (DIG_INT_MODE)
        begin
          words[0] = SAMPLE_DATA[31:16];
          words[1] = SAMPLE_DATA[15:0];
          words[2] = BKG_DATA[31:16];
          words[3] = BKG_DATA[15:0];
        end
      end
      FMT_CH32:
      begin
        if (!DIG_INT_MODE)
        begin
          n_words = 4'h8;
          for (int i = 0; i < NUM_CH; i++)
          begin
            words[2*i]   = ch[i][31:16];
            words[2*i+1] = ch[i][15:0];
          end
        end
      end
      default: n_words = 4'h0;
    endcase
  end

  // ----------------------------------------------------------------
  // fifo push sequencer
  // ----------------------------------------------------------------

  // first word leaves on the start edge, the rest one per cycle
  always_comb
  begin
    state_next     = state_reg;
    wbuf_next      = wbuf_reg;
    n_next         = n_reg;
    idx_next       = idx_reg;
    fifo_wr_next   = 1'b0;
    fifo_data_next = fifo_data_reg;
    case (state_reg)
      SFSC_IDLE:
      begin
        if (start)
        begin
          wbuf_next      = words;
          n_next         = n_words;
          idx_next       = 4'h1;
          fifo_wr_next   = 1'b1;
          fifo_data_next = words[0];
          if (n_words > 4'h1)
          begin
            state_next = SFSC_PUSH;
          end
        end
      end
      SFSC_PUSH:
      begin
        fifo_wr_next   = 1'b1;
        fifo_data_next = wbuf_reg[idx_reg[2:0]];
        idx_next       = idx_reg + 4'h1;
        if (idx_reg == n_reg - 4'h1)
        begin
          state_next = SFSC_IDLE;
        end
      end
      default: state_next = SFSC_IDLE;
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      state_reg     <= SFSC_IDLE;
      n_reg         <= 4'h0;
      idx_reg       <= 4'h0;
      fifo_wr_reg   <= 1'b0;
      fifo_data_reg <= '0;
      for (int i = 0; i < MAX_WORDS; i++)
      begin
        wbuf_reg[i] <= '0;
      end
    end
    else
    begin
      state_reg     <= state_next;
      n_reg         <= n_next;
      idx_reg       <= idx_next;
      fifo_wr_reg   <= fifo_wr_next;
      fifo_data_reg <= fifo_data_next;
      wbuf_reg      <= wbuf_next;
    end
  end

  assign FIFO_WR   = fifo_wr_reg;
  assign FIFO_DATA = fifo_data_reg;
  assign REG_RDATA = rdata_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  fmt_zero_a: assert property (@(posedge CLK) disable iff (RST)
    (state_reg == SFSC_IDLE && fifo_fmt == FMT_NONE) |=> !FIFO_WR)
    else $error("format zero pushed a word");

  fmt_one_a: assert property (@(posedge CLK) disable iff (RST)
    (start && fifo_fmt == FMT_W16) |=> (FIFO_WR && FIFO_DATA ==
      ($past(DIG_INT_MODE) ? $past(SAMPLE_DATA[15:0]) : $past(sum16))))
    else $error("format one word wrong");

  fmt_two_a: assert property (@(posedge CLK) disable iff (RST)
    (start && fifo_fmt == FMT_W32 && DIG_INT_MODE) |=>
      (FIFO_WR && FIFO_DATA == $past(SAMPLE_DATA[31:16])) ##1
      (FIFO_WR && FIFO_DATA == $past(SAMPLE_DATA[15:0], 2)))
    else $error("format two words wrong");

  fmt_three_a: assert property (@(posedge CLK) disable iff (RST)
    (start && fifo_fmt == FMT_W16BG) |=>
      (FIFO_WR && FIFO_DATA == $past(SAMPLE_DATA[15:0])) ##1
      (FIFO_WR && FIFO_DATA == $past(BKG_DATA[15:0], 2)))
    else $error("format three words wrong");

  fmt_four_a: assert property (@(posedge CLK) disable iff (RST)
    (start && fifo_fmt == FMT_W32BG) |=> FIFO_WR[*4])
    else $error("format four did not push four words");

  fmt_six_a: assert property (@(posedge CLK) disable iff (RST)
    (start && fifo_fmt == FMT_CH32) |=> FIFO_WR[*8])
    else $error("format six did not push eight words");

  slot_off_a: assert property (@(posedge CLK) disable iff (RST)
    (state_reg == SFSC_IDLE && !slot_en) |=> !FIFO_WR)
    else $error("disabled slot pushed a word");

  mode_gate_a: assert property (@(posedge CLK) disable iff (RST)
    (state_reg == SFSC_IDLE && op_mode != MODE_NORMAL) |=> !FIFO_WR)
    else $error("push outside normal operation");
endmodule // sfsc_top

// *** logic/sfsc_pkg.sv ***
// constants of the slot fifo format and sync configuration block
package sfsc_pkg;
  // ----------------------------------------------------------------
  // bus widths, channel count and word limit
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned CH_W   = 32;
  localparam int unsigned NUM_CH = 4;
  localparam int unsigned MAX_WORDS = 8;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_OPMODE    = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_SLOT_FIFO = 8'h11;
  localparam logic [ADDR_W-1:0] OFF_SYNC_TRIG = 8'h38;
  localparam logic [ADDR_W-1:0] OFF_SMP_CLK   = 8'h4B;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] RST_OPMODE    = 16'h0000;
  localparam logic [DATA_W-1:0] RST_SLOT_FIFO = 16'h1000;
  localparam logic [DATA_W-1:0] RST_SYNC_TRIG = 16'h0000;
  localparam logic [DATA_W-1:0] RST_SMP_CLK   = 16'h2612;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned OPMODE_LSB     = 0;
  localparam int unsigned SLOT_EN_BIT    = 0;
  localparam int unsigned FIFO_FMT_LSB   = 2;
  localparam int unsigned EXT_TRIG_BIT   = 14;

  // ----------------------------------------------------------------
  // operating modes and fifo formats
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_STANDBY = 2'h0;
  localparam logic [1:0] MODE_PROGRAM = 2'h1;
  localparam logic [1:0] MODE_NORMAL  = 2'h2;

  localparam logic [2:0] FMT_NONE  = 3'h0;
  localparam logic [2:0] FMT_W16   = 3'h1;
  localparam logic [2:0] FMT_W32   = 3'h2;
  localparam logic [2:0] FMT_W16BG = 3'h3;
  localparam logic [2:0] FMT_W32BG = 3'h4;
  localparam logic [2:0] FMT_CH32  = 3'h6;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS     = 8;
  localparam int unsigned SAMPLE_PERIOD_NS  = 10000;
  localparam int unsigned SAMPLE_PERIOD_CYC = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

  typedef enum logic {SFSC_IDLE, SFSC_PUSH} sfsc_state_e;
endpackage

// *** logic/sfsc_trig.sv ***
// sample trigger source: internal period timer or external sync edge
`timescale 1ns/1ps
module sfsc_trig
  import sfsc_pkg::*;
#(
  parameter int unsigned PERIOD_CYC = SAMPLE_PERIOD_CYC
)(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic run,
  input  wire logic ext_en,
  input  wire logic ext_sync,
  output logic      trig
);
  localparam int unsigned CW = $clog2(PERIOD_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(PERIOD_CYC - 1);

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          ext_prev_reg;
  logic          ext_prev_next;
  logic          tick;
  logic          ext_rise;

  // ----------------------------------------------------------------
  // period timer, held at zero outside normal operation
  // ----------------------------------------------------------------
  always_comb
  begin
    cnt_next      = cnt_reg;
    ext_prev_next = ext_sync;
    if (!run)
    begin
      cnt_next = '0;
    end
    else if (cnt_reg == LAST)
    begin
      cnt_next = '0;
    end
    else
    begin
      cnt_next = cnt_reg + CW'(1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_reg      <= '0;
      ext_prev_reg <= 1'b0;
    end
    else
    begin
      cnt_reg      <= cnt_next;
      ext_prev_reg <= ext_prev_next;
    end
  end

  // source select: timer tick or rising edge of the sync input
  assign tick     = run && (cnt_reg == LAST);
  assign ext_rise = ext_sync && !ext_prev_reg;
  assign trig     = ext_en ? ext_rise : tick;

  ext_trig_a: assert property (@(posedge clk) disable iff (rst)
    (ext_en && trig) |-> (ext_sync && !$past(ext_sync)))
    else $error("external trigger without sync edge");

  int_trig_a: assert property (@(posedge clk) disable iff (rst)
    (!ext_en && trig) |-> (run && cnt_reg == LAST))
    else $error("internal trigger off the timer wrap");
endmodule // sfsc_trig

// *** verif/test_slot_fifo_format_sync_config.sv ***
// self-checking bench for the slot fifo format, slot enable and trigger block
`timescale 1ns/1ps
module test_slot_fifo_format_sync_config;
  import sfsc_pkg::*;
  // ----------------------------------------------------------------
  // signals and stimulus table
  // ----------------------------------------------------------------
  localparam int unsigned PER = 8;  // shortened sample period
  typedef struct {
    logic [2:0]   fmt;
    logic         di;
    int           n;
    logic [127:0] w;  // word k sits in w[16*k +: 16]
  } sfsc_row_s;
  logic                clk        = 1'b0;
  logic                rst        = 1'b1;
  logic                reg_wr     = 1'b0;
  logic                reg_rd     = 1'b0;
  logic [ADDR_W-1:0]   reg_addr   = 8'h00;
  logic [DATA_W-1:0]   reg_wdata  = 16'h0000;
  logic [DATA_W-1:0]   reg_rdata;
  logic                ext_sync   = 1'b0;
  logic                di_mode    = 1'b0;
  logic [CH_W-1:0]     ch0        = 32'h1111_0001;
  logic [CH_W-1:0]     ch1        = 32'h2222_0002;
  logic [CH_W-1:0]     ch2        = 32'h3333_0003;
  logic [CH_W-1:0]     ch3        = 32'h4444_0004;
  logic [CH_W-1:0]     smp        = 32'hABCD_1234;
  logic [CH_W-1:0]     bkg        = 32'h5566_7788;
  logic                fifo_wr;
  logic [DATA_W-1:0]   fifo_data;
  int                  n_fail     = 0;
  int                  checks_done = 0;
  int                  k;
  int                  t0;
  int                  t1;
  // channel sum is 32'hAAAA_000A
  sfsc_row_s rows [13] = '{
    '{3'h0, 1'b1, 0, 128'h0},
    '{3'h1, 1'b1, 1, 128'h1234},
    '{3'h1, 1'b0, 1, 128'h000A},
    '{3'h2, 1'b1, 2, 128'h1234_ABCD},
    '{3'h2, 1'b0, 2, 128'h000A_AAAA},
    '{3'h3, 1'b1, 2, 128'h7788_1234},
    '{3'h3, 1'b0, 0, 128'h0},
    '{3'h4, 1'b1, 4, 128'h7788_5566_1234_ABCD},
    '{3'h4, 1'b0, 4, 128'h0004_0003_0002_0001},
    '{3'h6, 1'b0, 8, 128'h0004_4444_0003_3333_0002_2222_0001_1111},
    '{3'h6, 1'b1, 0, 128'h0},
    '{3'h5, 1'b0, 0, 128'h0},
    '{3'h7, 1'b1, 0, 128'h0}
  };

  // clock of 8 ns period
  always #4 clk = ~clk;

  sfsc_top #(
    .PERIOD_CYC (PER)
  ) sfsc_top_i (
    .CLK          (clk),
    .RST          (rst),
    .REG_WR       (reg_wr),
    .REG_RD       (reg_rd),
    .REG_ADDR     (reg_addr),
    .REG_WDATA    (reg_wdata),
    .REG_RDATA    (reg_rdata),
    .EXT_SYNC     (ext_sync),
    .DIG_INT_MODE (di_mode),
    .CH0_DATA     (ch0),
    .CH1_DATA     (ch1),
    .CH2_DATA     (ch2),
    .CH3_DATA     (ch3),
    .SAMPLE_DATA  (smp),
    .BKG_DATA     (bkg),
    .FIFO_WR      (fifo_wr),
    .FIFO_DATA    (fifo_data)
  );

  // ----------------------------------------------------------------
  // compare, bus and run tasks
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_int(input string what, input int exp, input int got);
    checks_done++;
    if (got != exp)
    begin
      n_fail++;
      $display("wrong value %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // write strobe for one cycle, driven between edges
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  // read strobe for one cycle, data checked the cycle after
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    chk16("read data", exp, reg_rdata);
  endtask

  // reconfigure from standby, then enter the requested mode
  task automatic cfg(input logic [1:0] m, input logic [15:0] slot, input logic [15:0] trig);
    wr(OFF_OPMODE, 16'h0000);
    wr(OFF_SLOT_FIFO, slot);
    wr(OFF_SYNC_TRIG, trig);
    wr(OFF_OPMODE, {14'h0000, m});
  endtask

  task automatic pulse_sync();
    @(negedge clk);
    ext_sync = 1'b1;
    @(negedge clk);
    ext_sync = 1'b0;
  endtask

  // count pushed words from this falling edge on, so the first word is not missed
  task automatic count_push(input int cyc, input logic [127:0] w, output int n);
    n = 0;
    repeat (cyc)
    begin
      if (fifo_wr === 1'b1)
      begin
        if (n < 8)
          chk16("fifo word", w[16*n +: 16], fifo_data);
        n++;
      end
      @(negedge clk);
    end
  endtask

  // bounded wait for the next push
  task automatic wait_push(output int t);
    t = 0;
    while (fifo_wr !== 1'b1)
    begin
      @(negedge clk);
      t++;
      if (t > 4 * PER)
      begin
        n_fail++;
        $display("wrong value timer push expected within %0d seen none", 4 * PER);
        summarize();
      end
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    chk16("rdata after reset", 16'h0000, reg_rdata);
    rd(OFF_OPMODE, RST_OPMODE);
    rd(OFF_SLOT_FIFO, 16'h1000);
    rd(OFF_SYNC_TRIG, 16'h0000);
    rd(OFF_SMP_CLK, 16'h2612);
    rd(8'h20, 16'h0000);
    wr(OFF_SMP_CLK, 16'hA5C3);
    wr(8'h20, 16'hFFFF);
    rd(OFF_SMP_CLK, 16'hA5C3);
    rd(8'h20, 16'h0000);
    // format table, triggered by the external sync edge
    foreach (rows[i])
    begin
      di_mode = rows[i].di;
      cfg(MODE_NORMAL, {11'h080, rows[i].fmt, 1'b0, 1'b1}, 16'h4000);
      pulse_sync();
      count_push(12, rows[i].w, k);
      chk_int("word count", rows[i].n, k);
    end
    // slot disabled: a trigger pushes nothing
    di_mode = 1'b1;
    cfg(MODE_NORMAL, {11'h080, FMT_W32, 1'b0, 1'b0}, 16'h4000);
    pulse_sync();
    count_push(12, 128'h0, k);
    chk_int("disabled slot words", 0, k);
    // standby and program modes never sample
    for (int m = 0; m < 2; m++)
    begin
      cfg(m[1:0], {11'h080, FMT_W32, 1'b0, 1'b1}, 16'h4000);
      pulse_sync();
      count_push(12, 128'h0, k);
      chk_int("idle mode words", 0, k);
    end
    // internal timer: pushes spaced by the sample period
    cfg(MODE_NORMAL, {11'h080, FMT_W16, 1'b0, 1'b1}, 16'h0000);
    wait_push(t0);
    chk16("timer word", 16'h1234, fifo_data);
    @(negedge clk);
    wait_push(t1);
    chk_int("timer period", PER, t1 + 1);
    // reset in mid-run restores the registers
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    chk16("fifo push in reset", 16'h0000, {15'h0000, fifo_wr});
    chk16("fifo data in reset", 16'h0000, fifo_data);
    rst = 1'b0;
    rd(OFF_SLOT_FIFO, 16'h1000);
    rd(OFF_SYNC_TRIG, 16'h0000);
    rd(OFF_SMP_CLK, 16'h2612);
    count_push(2 * PER, 128'h0, k);
    chk_int("words after reset", 0, k);
    summarize();
  end
endmodule // test_slot_fifo_format_sync_config
